// ### hdl/ups_pin_signaling.sv
// Function
// R1: MCR bit0 set drives terminal-ready low
// R2: MCR bit1 set drives request-to-send low
// R3: MCR bit3 set drives user output B low
// R4: MCR bit2 set drives user output A low
// R5: reset makes all four modem outputs high
// R6: loopback forces all four modem outputs high
// R7: FCR bit3 picks DMA mode, FIFOs on
// R8: mode0 tx request low while transmitter empty
// R9: mode1 tx request low while FIFO not full
// R10: mode0 rx request low while data held
// R11: mode1 rx request low on trigger/timeout
// R12: DMA may burst fill or drain in mode1
// R13: driver disable low during every CPU read
// R14: baud clock equals reference over divisor
// R15: interrupt high when enabled source active
// R16: interrupt low when serviced or reset
// R17: serial output marks high after reset
// R18: data bus driven only on CPU reads
// R19: reset clears MCR; bits 5-7 read zero
// R20: receiver clock supplied at 16x baud
// R21: MCR bit4 enters loopback mode
//
// Implementation choices: the address map and the APB interface to the registers.
module ups_pin_signaling #(
  parameter int FIFO_DEPTH = ups_pkg::FIFO_DEPTH,
  parameter int DIV_W      = ups_pkg::DIV_W
) (
  input  logic                  clk,
  input  logic                  rst,
  // APB slave
  input  logic                  psel,
  input  logic                  penable,
  input  logic                  pwrite,
  input  logic [7:0]            paddr,
  input  logic [31:0]           pwdata,
  output logic [31:0]           prdata,
  output logic                  pready,
  output logic                  pslverr,
  // from the framing engine and FIFOs
  input  ups_pkg::ups_fifo_stat_t fifoStat,
  input  ups_pkg::ups_tx_line_t   txLine,
  input  logic [ups_pkg::IRQ_N-1:0] irqSrc,
  // pins
  output logic                  terminal_ready_n,
  output logic                  request_to_send_n,
  output logic                  user_output_a_n,
  output logic                  user_output_b_n,
  output logic                  tx_dma_request_n,
  output logic                  rx_dma_request_n,
  output logic                  transceiver_disable,
  output logic                  baud16_clock_out_n,
  output logic                  baud16Tick,
  output logic                  irq_out,
  output logic                  serial_tx,
  output logic                  loopbackMode
);

  // ---------------------------------------------------------------
  // bus decode
  // ---------------------------------------------------------------
  logic wrEn;
  logic rdPhase;
  logic addrHit;

  assign pready  = 1'b1;
  assign wrEn    = psel && penable && pwrite;
  assign rdPhase = psel && !pwrite;

  always_comb
  begin
    case (paddr)
      ups_pkg::ADDR_MCTL,
      ups_pkg::ADDR_FCTL,
      ups_pkg::ADDR_IEN,
      ups_pkg::ADDR_DIVLO,
      ups_pkg::ADDR_DIVHI,
      ups_pkg::ADDR_PINSTS: addrHit = 1'b1;
      default:              addrHit = 1'b0;
    endcase
  end

  assign pslverr = psel && penable && !addrHit;

  // ---------------------------------------------------------------
  // modem control register
  // ---------------------------------------------------------------
  logic [ups_pkg::MCTL_W-1:0] mctl_r;

  always_ff @(posedge clk)
  begin
    if (rst)
      mctl_r <= ups_pkg::MCTL_RST;  // see R19
    else if (wrEn && paddr == ups_pkg::ADDR_MCTL)
      mctl_r <= pwdata[ups_pkg::MCTL_W-1:0];
  end

  assign loopbackMode = mctl_r[ups_pkg::MCTL_LOOP_BIT];  // see R21

  // ---------------------------------------------------------------
  // fifo control register
  // ---------------------------------------------------------------
  logic fifoEn_r;
  logic dmaMode_r;
  logic mode1;

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      fifoEn_r  <= ups_pkg::FCTL_FIFO_EN_RST;
      dmaMode_r <= ups_pkg::FCTL_DMA_MODE_RST;
    end
    else if (wrEn && paddr == ups_pkg::ADDR_FCTL)
    begin
      fifoEn_r  <= pwdata[ups_pkg::FCTL_FIFO_EN_BIT];
      dmaMode_r <= pwdata[ups_pkg::FCTL_DMA_MODE_BIT];
    end
  end

  // without FIFOs only single-transfer signalling exists
  assign mode1 = fifoEn_r && dmaMode_r;  // see R7

  // ---------------------------------------------------------------
  // interrupt enable and divisor registers
  // ---------------------------------------------------------------
  logic [ups_pkg::IRQ_N-1:0] ien_r;
  logic [DIV_W-1:0]          div_r;
  logic                      divLoad_r;

  always_ff @(posedge clk)
  begin
    if (rst)
      ien_r <= ups_pkg::IEN_RST;
    else if (wrEn && paddr == ups_pkg::ADDR_IEN)
      ien_r <= pwdata[ups_pkg::IRQ_N-1:0];
  end

  // divisor clears on reset, which parks the baud pin high until programmed
  always_ff @(posedge clk)
  begin
    if (rst)
      div_r <= DIV_W'(ups_pkg::DIV_RST);
    else if (wrEn && paddr == ups_pkg::ADDR_DIVLO)
      div_r[7:0] <= pwdata[7:0];
    else if (wrEn && paddr == ups_pkg::ADDR_DIVHI)
      div_r[DIV_W-1:8] <= pwdata[DIV_W-9:0];
  end

  // a new divisor restarts the divider so no stretched period
  always_ff @(posedge clk)
  begin
    if (rst)
      divLoad_r <= 1'b0;
    else
      divLoad_r <= wrEn && (paddr == ups_pkg::ADDR_DIVLO
                            || paddr == ups_pkg::ADDR_DIVHI);
  end

  // ---------------------------------------------------------------
  // modem control outputs
  // ---------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (rst || loopbackMode)
    begin
      terminal_ready_n  <= 1'b1;  // see R5, R6
      request_to_send_n <= 1'b1;
      user_output_a_n   <= 1'b1;
      user_output_b_n   <= 1'b1;
    end
    else
    begin
      terminal_ready_n  <= !mctl_r[ups_pkg::MCTL_TERM_BIT];  // see R1
      request_to_send_n <= !mctl_r[ups_pkg::MCTL_RTS_BIT];   // see R2
      user_output_a_n   <= !mctl_r[ups_pkg::MCTL_USRA_BIT];  // see R4
      user_output_b_n   <= !mctl_r[ups_pkg::MCTL_USRB_BIT];  // see R3
    end
  end

  // ---------------------------------------------------------------
  // DMA request pins
  // ---------------------------------------------------------------
  logic txEmpty;
  logic txFull;
  logic rxEmpty;
  logic rxArm_r;

  assign txEmpty = fifoStat.txCount == '0;
  assign txFull  = fifoStat.txCount >= ups_pkg::CNT_W'(FIFO_DEPTH);
  assign rxEmpty = fifoStat.rxCount == '0;

  // mode1 rx request latches on threshold and holds until drained,
  // which lets the controller burst the whole FIFO out
  always_ff @(posedge clk)
  begin
    if (rst)
      rxArm_r <= 1'b0;
    else if (fifoStat.rxTrigger || fifoStat.rxTimeout)
      rxArm_r <= 1'b1;  // see R11
    else if (rxEmpty)
      rxArm_r <= 1'b0;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      tx_dma_request_n <= 1'b1;
    else if (mode1)
      tx_dma_request_n <= txFull;  // see R9, R12
    else
      tx_dma_request_n <= !txEmpty;  // see R8
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      rx_dma_request_n <= 1'b1;
    else if (mode1)
      rx_dma_request_n <= !(rxArm_r && !rxEmpty);  // see R11, R12
    else
      rx_dma_request_n <= rxEmpty;  // see R10
  end

  // ---------------------------------------------------------------
  // bus transceiver direction
  // ---------------------------------------------------------------
  // combinational so the transceiver turns in the setup cycle
  assign transceiver_disable = !rdPhase;  // see R13

  // ---------------------------------------------------------------
  // baud rate generator
  // ---------------------------------------------------------------
  logic [DIV_W-1:0] baudCnt_r;
  logic             baudWrap;

  assign baudWrap = baudCnt_r >= div_r - DIV_W'(1);

  always_ff @(posedge clk)
  begin
    if (rst || divLoad_r || div_r == '0)
      baudCnt_r <= '0;
    else if (baudWrap)
      baudCnt_r <= '0;
    else
      baudCnt_r <= baudCnt_r + DIV_W'(1);
  end

  // one low cycle per divisor period; a zero divisor parks it high
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      baud16_clock_out_n <= 1'b1;
      baud16Tick         <= 1'b0;
    end
    else
    begin
      baud16_clock_out_n <= !(div_r != '0 && baudWrap);  // see R14
      baud16Tick         <= div_r != '0 && baudWrap;
    end
  end

  // ---------------------------------------------------------------
  // interrupt output
  // ---------------------------------------------------------------
  logic [ups_pkg::IRQ_N-1:0] irqLive;

  genvar gi;
  generate
    for (gi = 0; gi < ups_pkg::IRQ_N; gi++)
    begin : g_irq
      if (gi == ups_pkg::IRQ_TIMEOUT)
      begin : g_tmo
        // timeout exists only in FIFO operation
        assign irqLive[gi] = irqSrc[gi] && ien_r[gi] && fifoEn_r;
      end
      else
      begin : g_std
        assign irqLive[gi] = irqSrc[gi] && ien_r[gi];  // see R15
      end
    end
  endgenerate

  // sources are levels owned by the core; servicing drops them
  always_ff @(posedge clk)
  begin
    if (rst)
      irq_out <= 1'b0;  // see R16
    else
      irq_out <= |irqLive;  // see R15, R16
  end

  // ---------------------------------------------------------------
  // serial output idle level
  // ---------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (rst)
      serial_tx <= 1'b1;  // see R17
    else if (txLine.txActive && !loopbackMode)
      serial_tx <= txLine.txBit;
    else
      serial_tx <= 1'b1;  // see R17
  end

  // ---------------------------------------------------------------
  // read data; only low byte carries data like the 8-bit bus
  // ---------------------------------------------------------------
  logic [7:0] rdByte;

  always_comb
  begin
    rdByte = 8'h00;
    case (paddr)
      ups_pkg::ADDR_MCTL:
        rdByte = {3'h0, mctl_r};  // see R19
      ups_pkg::ADDR_FCTL:
        rdByte = {4'h0, dmaMode_r, 2'h0, fifoEn_r};
      ups_pkg::ADDR_IEN:
        rdByte = {3'h0, ien_r};
      ups_pkg::ADDR_DIVLO:
        rdByte = div_r[7:0];
      ups_pkg::ADDR_DIVHI:
        rdByte = div_r[DIV_W-1:8];
      ups_pkg::ADDR_PINSTS:
        rdByte = {serial_tx, irq_out, rx_dma_request_n,
                  tx_dma_request_n, user_output_b_n,
                  user_output_a_n, request_to_send_n,
                  terminal_ready_n};
      default:
        rdByte = 8'h00;
    endcase
  end

  // data leaves only during a read access  see R18
  assign prdata = (rdPhase && penable) ? {24'h000000, rdByte}
                                        : 32'h00000000;

endmodule

// ### hdl/ups_pkg.sv
package ups_pkg;

  // ---------------------------------------------------------------
  // register map, byte addresses
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_MCTL   = 8'h00;
  localparam logic [7:0] ADDR_FCTL   = 8'h04;
  localparam logic [7:0] ADDR_IEN    = 8'h08;
  localparam logic [7:0] ADDR_DIVLO  = 8'h0C;
  localparam logic [7:0] ADDR_DIVHI  = 8'h10;
  localparam logic [7:0] ADDR_PINSTS = 8'h14;

  // ---------------------------------------------------------------
  // modem control fields
  // ---------------------------------------------------------------
  localparam int MCTL_W        = 5;
  localparam int MCTL_TERM_BIT = 0;
  localparam int MCTL_RTS_BIT  = 1;
  localparam int MCTL_USRA_BIT = 2;
  localparam int MCTL_USRB_BIT = 3;
  localparam int MCTL_LOOP_BIT = 4;
  localparam logic [4:0] MCTL_RST = 5'h00;

  // ---------------------------------------------------------------
  // fifo control fields
  // ---------------------------------------------------------------
  localparam int FCTL_FIFO_EN_BIT  = 0;
  localparam int FCTL_DMA_MODE_BIT = 3;
  localparam logic FCTL_FIFO_EN_RST  = 1'b0;
  localparam logic FCTL_DMA_MODE_RST = 1'b0;

  // ---------------------------------------------------------------
  // interrupt sources, one bit each
  // ---------------------------------------------------------------
  localparam int IRQ_N       = 5;
  localparam int IRQ_RXDATA  = 0;
  localparam int IRQ_THRE    = 1;
  localparam int IRQ_RXERR   = 2;
  localparam int IRQ_MODEM   = 3;
  localparam int IRQ_TIMEOUT = 4;
  localparam logic [4:0] IEN_RST = 5'h00;

  // ---------------------------------------------------------------
  // baud divisor and fifo geometry
  // ---------------------------------------------------------------
  localparam int DIV_W = 16;
  localparam logic [15:0] DIV_RST = 16'h0000;
  localparam int FIFO_DEPTH = 16;
  localparam int CNT_W = 5;

  typedef struct packed {
    logic [CNT_W-1:0] txCount;
    logic [CNT_W-1:0] rxCount;
    logic             rxTrigger;
    logic             rxTimeout;
  } ups_fifo_stat_t;

  typedef struct packed {
    logic txActive;
    logic txBit;
  } ups_tx_line_t;

endpackage

// ### verification/ups_pin_signaling_assertions.sv
module ups_pin_checker (
  input logic                       clk,
  input logic                       rst,
  input logic                       psel,
  input logic                       penable,
  input logic                       pwrite,
  input logic [7:0]                 paddr,
  input logic [31:0]                pwdata,
  input logic [31:0]                prdata,
  input logic                       pready,
  input logic                       pslverr,
  input ups_pkg::ups_fifo_stat_t    fifoStat,
  input ups_pkg::ups_tx_line_t      txLine,
  input logic [ups_pkg::IRQ_N-1:0]  irqSrc,
  input logic                       terminal_ready_n,
  input logic                       request_to_send_n,
  input logic                       user_output_a_n,
  input logic                       user_output_b_n,
  input logic                       tx_dma_request_n,
  input logic                       rx_dma_request_n,
  input logic                       transceiver_disable,
  input logic                       baud16_clock_out_n,
  input logic                       baud16Tick,
  input logic                       irq_out,
  input logic                       serial_tx,
  input logic                       loopbackMode
);
  timeunit 1ns;
  timeprecision 1ns;
  logic m1_r;
  logic wrM;
  logic rdA;
  assign wrM = psel && penable && pwrite && paddr == ups_pkg::ADDR_MCTL;
  assign rdA = psel && penable && !pwrite;
  // dma mode as software last set it; needs both fifo enable and mode bit
  always_ff @(posedge clk)
    if (rst)
      m1_r <= 1'b0;
    else if (psel && penable && pwrite && paddr == ups_pkg::ADDR_FCTL)
      m1_r <= pwdata[0] & pwdata[3];
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // pins follow the stored register one edge later, so two edges after the write
  AST_TERM: assert property (wrM |-> ##2
    terminal_ready_n == $past(!pwdata[0] | pwdata[4], 2)) else $error("terminal ready wrong");
  AST_RTS: assert property (wrM |-> ##2
    request_to_send_n == $past(!pwdata[1] | pwdata[4], 2)) else $error("request to send wrong");
  AST_USRA: assert property (wrM |-> ##2
    user_output_a_n == $past(!pwdata[2] | pwdata[4], 2)) else $error("user output a wrong");
  AST_USRB: assert property (wrM |-> ##2
    user_output_b_n == $past(!pwdata[3] | pwdata[4], 2)) else $error("user output b wrong");
  AST_RESET: assert property (@(posedge clk) disable iff (1'b0) rst |=> terminal_ready_n
    && request_to_send_n && user_output_a_n && user_output_b_n && serial_tx && !irq_out)
    else $error("reset state wrong");
  AST_TRANSCEIVER_DISABLE: assert property (transceiver_disable == !(psel && !pwrite))
    else $error("driver disable wrong");
  AST_BUS: assert property (!rdA |-> prdata == 32'h0)
    else $error("data driven outside read");
  AST_MCTL_RD: assert property (rdA && paddr == ups_pkg::ADDR_MCTL |-> prdata[31:5] == 27'h0)
    else $error("modem control high bits set");
  AST_TX0: assert property (!$past(rst) && !$past(m1_r) |->
    tx_dma_request_n == ($past(fifoStat.txCount) != 5'h00)) else $error("tx request mode 0");
  AST_TX1: assert property (!$past(rst) && $past(m1_r) |->
    tx_dma_request_n == ($past(fifoStat.txCount) >= 5'h10)) else $error("tx request mode 1");
  AST_RX0: assert property (!$past(rst) && !$past(m1_r) |->
    rx_dma_request_n == ($past(fifoStat.rxCount) == 5'h00)) else $error("rx request mode 0");
  AST_SER: assert property (!$past(rst) |-> serial_tx ==
    ($past(txLine.txActive && !loopbackMode) ? $past(txLine.txBit) : 1'b1))
    else $error("serial output wrong");
  cover property ($past(m1_r) && tx_dma_request_n);
  cover property ($fell(rx_dma_request_n));
  cover property ($fell(baud16_clock_out_n));
endmodule

// ### verification/ups_fifo_model.sv
module ups_fifo_model (
  input  logic                    clk,
  input  logic                    rst,
  input  logic [3:0]              ctl,
  input  logic                    rxTrig,
  input  logic                    rxTmo,
  output ups_pkg::ups_fifo_stat_t fifoStat
);
  timeunit 1ns;
  timeprecision 1ns;
  // dma side keeps pushing or popping; a full or empty fifo just refuses
  always_ff @(posedge clk)
    if (rst)
      fifoStat <= '0;
    else
    begin
      if (ctl[3] && fifoStat.txCount < ups_pkg::FIFO_DEPTH)
        fifoStat.txCount <= fifoStat.txCount + 5'h01;
      else if (ctl[2] && fifoStat.txCount != 5'h00)
        fifoStat.txCount <= fifoStat.txCount - 5'h01;
      if (ctl[1] && fifoStat.rxCount < ups_pkg::FIFO_DEPTH)
        fifoStat.rxCount <= fifoStat.rxCount + 5'h01;
      else if (ctl[0] && fifoStat.rxCount != 5'h00)
        fifoStat.rxCount <= fifoStat.rxCount - 5'h01;
      fifoStat.rxTrigger <= rxTrig;
      fifoStat.rxTimeout <= rxTmo;
    end
endmodule

// ### verification/ups_pin_signaling_tb.sv
module ups_pin_signaling_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rdata;
  logic pready, pslverr, rerr, rxTrig = 1'b0, rxTmo = 1'b0;
  logic [3:0] ctl = 4'h0;
  ups_pkg::ups_fifo_stat_t fifoStat;
  ups_pkg::ups_tx_line_t txLine = 2'h0;
  logic [4:0] irqSrc = 5'h00;
  logic terminal_ready_n, request_to_send_n, user_output_a_n, user_output_b_n;
  logic tx_dma_request_n, rx_dma_request_n, transceiver_disable, baud16_clock_out_n;
  logic baud16Tick, irq_out, serial_tx, loopbackMode;
  int n_errors = 0, tests_run = 0;
  ups_pin_signaling u_ups_pin_signaling (.*);
  ups_fifo_model u_ups_fifo_model (.clk(clk), .rst(rst), .ctl(ctl), .rxTrig(rxTrig),
    .rxTmo(rxTmo), .fifoStat(fifoStat));
  always #25 clk = ~clk;
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e)
    begin
      n_errors++;
      $display("unexpected %s: expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge clk);
  endtask
  // two idle edges after each transfer so registered pins have settled
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do
    begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (pready !== 1'b1)
    begin
      n_errors++;
      $display("unexpected pready: expected 1 seen %b", pready);
    end
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    idle(2);
  endtask
  task automatic fifo(input logic [3:0] c, input int n);
    @(posedge clk);
    ctl <= c;
    repeat (n) @(posedge clk);
    ctl <= 4'h0;
    idle(3);
  endtask
  task automatic t_reset;
    apb(1'b0, ups_pkg::ADDR_PINSTS, 32'h0);
    chk("pin status", 32'hAF, rdata);
    for (int a = 0; a < 5; a++)
    begin
      apb(1'b0, 8'(a * 4), 32'h0);
      chk("register reset", 32'h0, rdata);
    end
  endtask
  task automatic t_modem;
    logic [3:0] e;
    for (int v = 0; v < 32; v++)
    begin
      apb(1'b1, ups_pkg::ADDR_MCTL, 32'(v));
      e = v[4] ? 4'hF : ~v[3:0];
      chk("modem pins", 32'(e), {user_output_b_n, user_output_a_n,
        request_to_send_n, terminal_ready_n});
      chk("loopback", v[4], loopbackMode);
    end
    apb(1'b1, ups_pkg::ADDR_MCTL, 32'hFF);
    apb(1'b0, ups_pkg::ADDR_MCTL, 32'h0);
    chk("modem readback", 32'h1F, rdata);
    apb(1'b1, ups_pkg::ADDR_MCTL, 32'h0);
  endtask
  task automatic t_dma;
    fifo(4'h8, 3);
    apb(1'b1, ups_pkg::ADDR_FCTL, 32'h9);
    chk("tx mode 1", 1'b0, tx_dma_request_n);
    apb(1'b1, ups_pkg::ADDR_FCTL, 32'h8);
    chk("tx fifo off", 1'b1, tx_dma_request_n);
    apb(1'b1, ups_pkg::ADDR_FCTL, 32'h1);
    chk("tx mode 0", 1'b1, tx_dma_request_n);
    fifo(4'h4, 20);
    chk("tx mode 0 empty", 1'b0, tx_dma_request_n);
    apb(1'b1, ups_pkg::ADDR_FCTL, 32'h9);
    fifo(4'h8, 20);
    chk("tx full", 1'b1, tx_dma_request_n);
    fifo(4'h4, 1);
    chk("tx one free", 1'b0, tx_dma_request_n);
    fifo(4'h4, 20);
    fifo(4'h2, 2);
    chk("rx below trigger", 1'b1, rx_dma_request_n);
    @(posedge clk);
    rxTrig <= 1'b1;
    @(posedge clk);
    rxTrig <= 1'b0;
    idle(3);
    chk("rx trigger", 1'b0, rx_dma_request_n);
    fifo(4'h1, 20);
    chk("rx drained", 1'b1, rx_dma_request_n);
    fifo(4'h2, 2);
    @(posedge clk);
    rxTmo <= 1'b1;
    @(posedge clk);
    rxTmo <= 1'b0;
    idle(3);
    chk("rx timeout", 1'b0, rx_dma_request_n);
    fifo(4'h1, 20);
    chk("rx timeout drained", 1'b1, rx_dma_request_n);
    apb(1'b1, ups_pkg::ADDR_FCTL, 32'h1);
    fifo(4'h2, 1);
    chk("rx mode 0", 1'b0, rx_dma_request_n);
    fifo(4'h1, 1);
    chk("rx mode 0 empty", 1'b1, rx_dma_request_n);
  endtask
  task automatic t_irq;
    @(posedge clk);
    irqSrc <= 5'h02;
    apb(1'b1, ups_pkg::ADDR_IEN, 32'h0);
    chk("irq masked", 1'b0, irq_out);
    apb(1'b1, ups_pkg::ADDR_IEN, 32'h1F);
    chk("irq raised", 1'b1, irq_out);
    @(posedge clk);
    irqSrc <= 5'h10;
    idle(3);
    chk("irq timeout", 1'b1, irq_out);
    apb(1'b1, ups_pkg::ADDR_FCTL, 32'h0);
    chk("irq timeout no fifo", 1'b0, irq_out);
    for (int i = 0; i < 4; i++)
    begin
      irqSrc <= 5'(1 << i);
      idle(3);
      chk("irq source", 1'b1, irq_out);
      irqSrc <= 5'h00;
      idle(3);
      chk("irq serviced", 1'b0, irq_out);
    end
  endtask
  task automatic t_misc;
    int c = 0;
    int t = 0;
    apb(1'b1, ups_pkg::ADDR_DIVLO, 32'h4);
    apb(1'b1, ups_pkg::ADDR_DIVHI, 32'h0);
    repeat (40)
    begin
      @(posedge clk);
      c += (baud16_clock_out_n === 1'b0);
      t += (baud16Tick === 1'b1);
    end
    chk("baud pulses", 32'd10, c);
    chk("receiver clock ticks", 32'd10, t);
    txLine <= 2'h2;
    idle(3);
    chk("serial bit", 1'b0, serial_tx);
    apb(1'b1, ups_pkg::ADDR_MCTL, 32'h10);
    chk("serial in loopback", 1'b1, serial_tx);
    apb(1'b0, 8'h3C, 32'h0);
    chk("unmapped error", 1'b1, rerr);
    // drive every modem pin low, then reset in mid-run
    apb(1'b1, ups_pkg::ADDR_MCTL, 32'h0F);
    @(posedge clk);
    rst <= 1'b1;
    txLine <= 2'h0;
    idle(2);
    rst <= 1'b0;
    idle(1);
    apb(1'b0, ups_pkg::ADDR_PINSTS, 32'h0);
    chk("pin status after reset", 32'hAF, rdata);
  endtask
  task automatic give_verdict;
    $display("errors %0d, checks %0d", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial
  begin
    idle(4);
    rst <= 1'b0;
    idle(1);
    t_reset();
    t_modem();
    t_dma();
    t_irq();
    t_misc();
    give_verdict();
  end
  initial
  begin
    #200us;
    n_errors++;
    give_verdict();
  end
endmodule
bind ups_pin_signaling ups_pin_checker u_ups_pin_checker (.*);
